// [hw/mpo_top.sv]
// Motor PWM channel output stage: counter start, buffered phase settings, six line drivers
//
// How it works
// - Sync enabled start waits for peer start
// - One write of both bits enters standby
// - First started channel waits, both start together
// - Output register: timing select plus buffered phases
// - Waveform select: 0 fixed level, 1 waveform
// - Polarity bits set upper and lower active level
// - Timing 00 now, 01 one, 10 period, 11 both
// - Phase writes go to buffer, load at timing
// - Fixed codes: 00 LL, 01 LH, 10 HL, 11 HH
// - Waveform codes: 01 upper off, 10 lower off
// - Active low inverts fixed levels only
// - V and W decode like U, independently
// - Start bit 0 stops and clears counter
`include "mpo_regs.svh"
module mpo_top #(
    parameter int DATA_W = 16,                            // Register width
    parameter int CNT_W  = 16                             // Counter width
) (
    input  wire logic              clk_i,                 // Clock, 25 MHz
    input  wire logic              sys_rst_i,             // Async reset, active high
    input  wire logic [31:0]       addr_i,                // Register byte address
    input  wire logic [DATA_W-1:0] wdata_i,               // Write data
    input  wire logic              wr_i,                  // Write strobe
    input  wire logic              rd_i,                  // Read strobe
    output logic      [DATA_W-1:0] rdata_o,               // Read data, cycle after strobe
    input  wire logic              peer_run_i,            // Peer channel start bit
    output logic                   local_run_o,           // Local start bit to peer
    input  wire logic [2:0]        wave_upper_i,          // Upper waveforms U V W
    input  wire logic [2:0]        wave_lower_i,          // Lower waveforms U V W
    output logic      [2:0]        upper_o,               // Upper lines U V W
    output logic      [2:0]        lower_o,               // Lower lines U V W
    output logic      [CNT_W-1:0]  count_o,               // Counter value
    output logic                   load_o                 // Phase settings load pulse
);

    // Address decode
    wire logic hit_ctrl;
    wire logic hit_count;
    wire logic hit_period;
    wire logic hit_out;

    assign hit_ctrl   = (addr_i == `MPO_ADDR_CHAN_CTRL);
    assign hit_count  = (addr_i == `MPO_ADDR_COUNT);
    assign hit_period = (addr_i == `MPO_ADDR_PERIOD);
    assign hit_out    = (addr_i == `MPO_ADDR_OUT_CTRL);

    // Write enables per register
    wire logic wr_ctrl;
    wire logic wr_period;
    wire logic wr_out;

    assign wr_ctrl    = wr_i & hit_ctrl;
    assign wr_period  = wr_i & hit_period;
    assign wr_out     = wr_i & hit_out;

    // Channel control bits
    logic run_q;
    logic run_d;
    logic sync_q;
    logic sync_d;

    // Both bits are taken from one write, so standby is entered directly
    assign run_d  = wr_ctrl ? wdata_i[`MPO_CTRL_RUN_BIT] : run_q;
    assign sync_d = wr_ctrl ? wdata_i[`MPO_CTRL_SYNC_BIT] : sync_q;

    // Period, buffered and active copies
    logic [CNT_W-1:0] period_buf_q;
    logic [CNT_W-1:0] period_buf_d;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] period_d;

    assign period_buf_d = wr_period ? wdata_i[CNT_W-1:0] : period_buf_q;

    // Unbuffered output control fields
    localparam logic [15:0] OUT_RST = `MPO_OUT_RESET; // Reset image
    logic [1:0] timing_q;
    logic [1:0] timing_d;
    logic       pol_hi_q;
    logic       pol_hi_d;
    logic       pol_lo_q;
    logic       pol_lo_d;

    // Timing and polarity act at once; software changes them while stopped
    assign timing_d = wr_out ? wdata_i[`MPO_OUT_TIMING_MSB:`MPO_OUT_TIMING_LSB]
                             : timing_q;
    assign pol_hi_d = wr_out ? wdata_i[`MPO_OUT_POL_HI_BIT] : pol_hi_q;
    assign pol_lo_d = wr_out ? wdata_i[`MPO_OUT_POL_LO_BIT] : pol_lo_q;

    // Buffered phase settings: codes and waveform selects
    logic [5:0] code_buf_q;
    logic [5:0] code_buf_d;
    logic [2:0] sel_buf_q;
    logic [2:0] sel_buf_d;
    logic [5:0] code_act_q;
    logic [5:0] code_act_d;
    logic [2:0] sel_act_q;
    logic [2:0] sel_act_d;

    // Writes land only in the buffer
    assign code_buf_d = wr_out ? wdata_i[`MPO_OUT_CODE_MSB:`MPO_OUT_CODE_LSB]
                               : code_buf_q;
    assign sel_buf_d  = wr_out ? wdata_i[`MPO_OUT_SEL_MSB:`MPO_OUT_SEL_LSB]
                               : sel_buf_q;

    // Counter and its compare points
    wire logic       standby;
    wire logic       at_one;
    wire logic       at_period;
    wire logic [CNT_W-1:0] count;

    mpo_counter #(
        .WIDTH       (CNT_W)
    ) u_counter (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .run_i       (run_q),
        .sync_i      (sync_q),
        .peer_run_i  (peer_run_i),
        .period_i    (period_q),
        .count_o     (count),
        .standby_o   (standby),
        .at_one_o    (at_one),
        .at_period_o (at_period)
    );

    // Decide whether this cycle moves the buffer into the active set
    function automatic logic mpo_load_now(input logic [1:0] timing,
                                          input logic       one,
                                          input logic       per);
        logic hit;
        hit = 1'b0;
        case (timing)
            `MPO_XFER_ASYNC:     hit = 1'b1;
            `MPO_XFER_AT_ONE:    hit = one;
            `MPO_XFER_AT_PERIOD: hit = per;
            `MPO_XFER_AT_BOTH:   hit = one | per;
            default:             hit = 1'b0;
        endcase
        return hit;
    endfunction : mpo_load_now

    wire logic load_phase;

    assign load_phase = mpo_load_now(timing_q, at_one, at_period);

    // Active phase settings follow the buffer only at the load point
    assign code_act_d = load_phase ? code_buf_q : code_act_q;
    assign sel_act_d  = load_phase ? sel_buf_q  : sel_act_q;

    // Period reloads at the period point, or at once while not counting
    wire logic load_period;

    assign load_period = at_period | (count == CNT_W'(`MPO_COUNT_CLEAR));
    assign period_d    = load_period ? period_buf_q : period_q;

    // Control registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q  <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            run_q  <= run_d;
            sync_q <= sync_d;
        end
    end

    // Period registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            period_buf_q <= CNT_W'(`MPO_PERIOD_RESET);
            period_q     <= CNT_W'(`MPO_PERIOD_RESET);
        end else begin
            period_buf_q <= period_buf_d;
            period_q     <= period_d;
        end
    end

    // Output control, unbuffered part
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            timing_q <= OUT_RST[`MPO_OUT_TIMING_MSB:`MPO_OUT_TIMING_LSB];
            pol_hi_q <= OUT_RST[`MPO_OUT_POL_HI_BIT];
            pol_lo_q <= OUT_RST[`MPO_OUT_POL_LO_BIT];
        end else begin
            timing_q <= timing_d;
            pol_hi_q <= pol_hi_d;
            pol_lo_q <= pol_lo_d;
        end
    end

    // Output control, buffered part
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            code_buf_q <= OUT_RST[`MPO_OUT_CODE_MSB:`MPO_OUT_CODE_LSB];
            sel_buf_q  <= OUT_RST[`MPO_OUT_SEL_MSB:`MPO_OUT_SEL_LSB];
            code_act_q <= OUT_RST[`MPO_OUT_CODE_MSB:`MPO_OUT_CODE_LSB];
            sel_act_q  <= OUT_RST[`MPO_OUT_SEL_MSB:`MPO_OUT_SEL_LSB];
        end else begin
            code_buf_q <= code_buf_d;
            sel_buf_q  <= sel_buf_d;
            code_act_q <= code_act_d;
            sel_act_q  <= sel_act_d;
        end
    end

    // Per-phase decode, same logic for U, V and W
    wire logic [2:0] upper_d;
    wire logic [2:0] lower_d;

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            mpo_phase_decode u_decode (
                .pwm_sel_i (sel_act_q[ph]),
                .code_i    (code_act_q[2*ph+1:2*ph]),
                .pol_hi_i  (pol_hi_q),
                .pol_lo_i  (pol_lo_q),
                .wave_hi_i (wave_upper_i[ph]),
                .wave_lo_i (wave_lower_i[ph]),
                .upper_o   (upper_d[ph]),
                .lower_o   (lower_d[ph])
            );
        end
    endgenerate

    // Read views
    wire logic [DATA_W-1:0] ctrl_view;
    wire logic [DATA_W-1:0] out_view;
    wire logic [DATA_W-1:0] rdata_d;

    // Standby shows in the control word so software can see the wait
    assign ctrl_view = DATA_W'({standby, 8'h00, sync_q, 5'h00, run_q});

    // Buffer contents read back; top three bits are zero
    assign out_view  = DATA_W'({3'b000, pol_hi_q, pol_lo_q, sel_buf_q,
                                timing_q, code_buf_q});

    // Read mux, unmapped addresses read zero
    assign rdata_d   = !rd_i       ? DATA_W'(0) :
                       hit_ctrl    ? ctrl_view :
                       hit_count   ? DATA_W'(count) :
                       hit_period  ? DATA_W'(period_buf_q) :
                       hit_out     ? out_view :
                       DATA_W'(0);

    // Registered outputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o     <= DATA_W'(0);
            local_run_o <= 1'b0;
            upper_o     <= 3'b000;
            lower_o     <= 3'b000;
            count_o     <= CNT_W'(`MPO_COUNT_CLEAR);
            load_o      <= 1'b0;
        end else begin
            rdata_o     <= rdata_d;
            local_run_o <= run_d;
            upper_o     <= upper_d;
            lower_o     <= lower_d;
            count_o     <= count;
            load_o      <= load_phase;
        end
    end

endmodule : mpo_top

// [inc/mpo_regs.svh]
// Register map, field positions, reset values and widths of the motor PWM output stage
`ifndef MPO_REGS_SVH
`define MPO_REGS_SVH

// Byte addresses
`define MPO_ADDR_CHAN_CTRL    32'hffff_c300
`define MPO_ADDR_COUNT        32'hffff_c304
`define MPO_ADDR_PERIOD       32'hffff_c308
`define MPO_ADDR_OUT_CTRL     32'hffff_c318

// Channel control fields
`define MPO_CTRL_RUN_BIT      0
`define MPO_CTRL_SYNC_BIT     6
`define MPO_CTRL_STANDBY_BIT  15

// Output control fields
`define MPO_OUT_CODE_LSB      0
`define MPO_OUT_CODE_MSB      5
`define MPO_OUT_TIMING_LSB    6
`define MPO_OUT_TIMING_MSB    7
`define MPO_OUT_SEL_LSB       8
`define MPO_OUT_SEL_MSB       10
`define MPO_OUT_POL_LO_BIT    11
`define MPO_OUT_POL_HI_BIT    12

// Transfer timing codes
`define MPO_XFER_ASYNC        2'b00
`define MPO_XFER_AT_ONE       2'b01
`define MPO_XFER_AT_PERIOD    2'b10
`define MPO_XFER_AT_BOTH      2'b11

// Reset values and the counter's first count
`define MPO_OUT_RESET         16'h0000
`define MPO_PERIOD_RESET      16'h0000
`define MPO_COUNT_FIRST       16'h0001
`define MPO_COUNT_CLEAR       16'h0000

`endif

// [inc/mpo_pkg.sv]
// Types shared by the motor PWM output stage
package mpo_pkg;

    // Counter run state
    typedef enum logic [1:0] {
        MPO_STOPPED = 2'b00,
        MPO_STANDBY = 2'b01,
        MPO_COUNTING = 2'b10
    } mpo_run_state_type;

    // Phase conduction code
    typedef logic [1:0] mpo_code_type;

endpackage : mpo_pkg

// [hw/mpo_phase_decode.sv]
// Conduction decode of one phase into its upper and lower line levels
module mpo_phase_decode (
    input  wire logic                  pwm_sel_i,   // 1 selects waveform output
    input  wire mpo_pkg::mpo_code_type code_i,      // Conduction code
    input  wire logic                  pol_hi_i,    // Upper polarity, 1 active high
    input  wire logic                  pol_lo_i,    // Lower polarity, 1 active high
    input  wire logic                  wave_hi_i,   // Upper waveform
    input  wire logic                  wave_lo_i,   // Lower waveform
    output wire logic                  upper_o,     // Upper line level
    output wire logic                  lower_o      // Lower line level
);

    // Fixed levels for active-high polarity
    wire logic fix_hi_ah;
    wire logic fix_lo_ah;
    // Waveform placement in waveform mode
    wire logic hi_is_wave;
    wire logic lo_is_wave;
    // Fixed levels after polarity
    wire logic fix_hi;
    wire logic fix_lo;

    // Fixed-level table: 00 L/L, 01 L/H, 10 H/L, 11 H/H
    assign fix_hi_ah  = code_i[1];
    assign fix_lo_ah  = code_i[0];

    // Waveform table: 01 upper inactive, 10 lower inactive, else both waveform
    assign hi_is_wave = pwm_sel_i & ~(code_i == 2'b01);
    assign lo_is_wave = pwm_sel_i & ~(code_i == 2'b10);

    // Polarity inverts fixed levels only; inactive equals low when active high
    assign fix_hi     = pwm_sel_i ? ~pol_hi_i : (fix_hi_ah ~^ pol_hi_i);
    assign fix_lo     = pwm_sel_i ? ~pol_lo_i : (fix_lo_ah ~^ pol_lo_i);

    // Mode select between fixed level and waveform
    assign upper_o    = hi_is_wave ? wave_hi_i : fix_hi;
    assign lower_o    = lo_is_wave ? wave_lo_i : fix_lo;

endmodule : mpo_phase_decode

// [hw/mpo_counter.sv]
// PWM counter with stop-and-clear and synchronized-start standby
`include "mpo_regs.svh"
module mpo_counter #(
    parameter int WIDTH = 16                             // Counter width
) (
    input  wire logic             clk_i,                 // Clock
    input  wire logic             sys_rst_i,             // Async reset, active high
    input  wire logic             run_i,                 // Counter start bit
    input  wire logic             sync_i,                // Synchronized start enable
    input  wire logic             peer_run_i,            // Peer channel start bit
    input  wire logic [WIDTH-1:0] period_i,              // Active period value
    output logic      [WIDTH-1:0] count_o,               // Counter value
    output wire logic             standby_o,             // Waiting for peer
    output wire logic             at_one_o,              // Counter equals 1
    output wire logic             at_period_o            // Counter equals period
);

    mpo_pkg::mpo_run_state_type state_q;
    mpo_pkg::mpo_run_state_type state_d;
    logic [WIDTH-1:0]           count_d;
    wire logic                  counting;
    wire logic                  wrap;

    assign counting    = (state_q == mpo_pkg::MPO_COUNTING);
    assign wrap        = counting && (count_o >= period_i);
    assign standby_o   = (state_q == mpo_pkg::MPO_STANDBY);
    assign at_one_o    = counting && (count_o == WIDTH'(`MPO_COUNT_FIRST));
    assign at_period_o = counting && (count_o == period_i);

    // Run state: standby holds until the peer start bit is set
    always_comb begin
        state_d = state_q;
        case (state_q)
            mpo_pkg::MPO_STOPPED: begin
                if (run_i && sync_i && !peer_run_i) begin
                    state_d = mpo_pkg::MPO_STANDBY;
                end else if (run_i) begin
                    state_d = mpo_pkg::MPO_COUNTING;
                end
            end
            mpo_pkg::MPO_STANDBY: begin
                if (!run_i) begin
                    state_d = mpo_pkg::MPO_STOPPED;
                end else if (peer_run_i) begin
                    state_d = mpo_pkg::MPO_COUNTING;
                end
            end
            mpo_pkg::MPO_COUNTING: begin
                if (!run_i) begin
                    state_d = mpo_pkg::MPO_STOPPED;
                end
            end
            default: state_d = mpo_pkg::MPO_STOPPED;
        endcase
    end

    // Count 1 to period, clear while not counting
    always_comb begin
        if (state_d != mpo_pkg::MPO_COUNTING) begin
            count_d = WIDTH'(`MPO_COUNT_CLEAR);
        end else if (!counting || wrap) begin
            count_d = WIDTH'(`MPO_COUNT_FIRST);
        end else begin
            count_d = count_o + WIDTH'(1);
        end
    end

    // State and counter flops
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= mpo_pkg::MPO_STOPPED;
            count_o <= WIDTH'(`MPO_COUNT_CLEAR);
        end else begin
            state_q <= state_d;
            count_o <= count_d;
        end
    end

endmodule : mpo_counter

// [tb/mpo_top_properties.sv]
// Port-level concurrent checks of the motor PWM output stage
`include "mpo_regs.svh"
module mpo_top_properties #(
    parameter int DATA_W = 16,                           // Register width
    parameter int CNT_W  = 16                            // Counter width
) (
    input wire logic              clk_i,                 // Clock
    input wire logic              sys_rst_i,             // Async reset
    input wire logic [31:0]       addr_i,                // Address
    input wire logic [DATA_W-1:0] wdata_i,               // Write data
    input wire logic              wr_i,                  // Write strobe
    input wire logic              rd_i,                  // Read strobe
    input wire logic [DATA_W-1:0] rdata_o,               // Read data
    input wire logic              peer_run_i,            // Peer start bit
    input wire logic              local_run_o,           // Local start bit
    input wire logic [2:0]        wave_upper_i,          // Upper waveforms
    input wire logic [2:0]        wave_lower_i,          // Lower waveforms
    input wire logic [2:0]        upper_o,               // Upper lines
    input wire logic [2:0]        lower_o,               // Lower lines
    input wire logic [CNT_W-1:0]  count_o,               // Counter value
    input wire logic              load_o                 // Load pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wu_q;                                    // Last upper waveforms
    logic [2:0] wl_q;                                    // Last lower waveforms
    logic [3:0] cause_q;                                 // Recent line-change causes
    // Anything that may legally move a line
    wire cause_w = wr_i | load_o | (wave_upper_i != wu_q) | (wave_lower_i != wl_q);
    wire run_bit_w = wdata_i[`MPO_CTRL_RUN_BIT];
    // Cause history, seeded so the post-reset settling is excused
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cause_q <= 4'hf;
            wu_q    <= 3'h0;
            wl_q    <= 3'h0;
        end else begin
            cause_q <= {cause_q[2:0], cause_w};
            wu_q    <= wave_upper_i;
            wl_q    <= wave_lower_i;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    AST_RDATA_IDLE: assert property (
        !$past(rd_i) |-> rdata_o == '0) else $error("read data not zero outside a read");
    AST_OUT_TOP_ZERO: assert property (
        $past(rd_i) && $past(addr_i) == `MPO_ADDR_OUT_CTRL |-> rdata_o[15:13] == 3'h0)
        else $error("output control top bits not zero");
    AST_RUN_FOLLOWS: assert property (
        wr_i && addr_i == `MPO_ADDR_CHAN_CTRL |=> local_run_o == $past(run_bit_w))
        else $error("start bit does not follow write");
    AST_STOP_CLEARS: assert property (
        !local_run_o [*3] |-> count_o == '0) else $error("stopped counter not cleared");
    AST_FIRST_ONE: assert property (
        count_o != '0 && $past(count_o) == '0 |-> count_o == CNT_W'(1))
        else $error("counter did not start at one");
    AST_COUNT_STEP: assert property (
        count_o != '0 && $past(count_o) != '0 && count_o != CNT_W'(1)
        |-> count_o == $past(count_o) + 1'b1) else $error("counter step not one");
    AST_PEER_START: assert property (
        local_run_o && $rose(peer_run_i) && count_o == '0 |-> ##[1:3] count_o == CNT_W'(1))
        else $error("standby did not start with peer");
    AST_LINES_HOLD: assert property (
        upper_o != $past(upper_o) || lower_o != $past(lower_o) |-> |{cause_q, cause_w})
        else $error("line changed without load, write or waveform");
    COV_WRAP: cover property (count_o == CNT_W'(1) && $past(count_o) != '0);
    COV_PEER: cover property ($rose(peer_run_i) && local_run_o);
    COV_LOAD: cover property (load_o && count_o != '0);
endmodule : mpo_top_properties

// [tb/mpo_gate_drive_model.sv]
// Behavioural inverter gate drive: line levels to switch states
module mpo_gate_drive_model (
    input  wire logic [2:0] upper_i,                     // Upper lines U V W
    input  wire logic [2:0] lower_i,                     // Lower lines U V W
    input  wire logic       pol_hi_i,                    // Upper active level
    input  wire logic       pol_lo_i,                    // Lower active level
    output wire logic [2:0] gate_upper_o,                // Upper switches on
    output wire logic [2:0] gate_lower_o                 // Lower switches on
);
    timeunit 1ns;
    timeprecision 1ps;
    // A switch conducts while its line sits at the active level
    assign gate_upper_o = upper_i ~^ {3{pol_hi_i}};
    assign gate_lower_o = lower_i ~^ {3{pol_lo_i}};
endmodule : mpo_gate_drive_model

// [tb/motor_pwm_output_conduction_tb_top.sv]
// Self-checking bench of the motor PWM output stage
`include "mpo_regs.svh"
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("ERROR %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module motor_pwm_output_conduction_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [31:0] addr_i = 32'h0000_0000;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        peer_run_i = 1'b0;
    logic [2:0]  wave_upper_i = 3'h0;
    logic [2:0]  wave_lower_i = 3'h0;
    logic        pol_hi = 1'b0;
    logic        pol_lo = 1'b0;
    logic [15:0] rdata_o, count_o;
    logic [2:0]  upper_o, lower_o, gate_u, gate_l;
    logic        local_run_o, load_o;
    int          mismatches = 0;
    int          comparisons = 0;
    // Clock, 40 ns period
    always #20 clk_i = ~clk_i;
    mpo_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .peer_run_i(peer_run_i),
        .local_run_o(local_run_o), .wave_upper_i(wave_upper_i), .wave_lower_i(wave_lower_i),
        .upper_o(upper_o), .lower_o(lower_o), .count_o(count_o), .load_o(load_o));
    mpo_gate_drive_model u_gate (.upper_i(upper_o), .lower_i(lower_o), .pol_hi_i(pol_hi),
        .pol_lo_i(pol_lo), .gate_upper_o(gate_u), .gate_lower_o(gate_l));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        while (count_o !== v && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK("count reached", v, count_o)
    endtask : wait_cnt
    task automatic chk_lines(input logic [1:0] cd);
        `CHK("upper lines", {3{cd[1]}}, upper_o)
        `CHK("lower lines", {3{cd[0]}}, lower_o)
    endtask : chk_lines
    task automatic t_reset;
        logic [15:0] d;
        rd(`MPO_ADDR_OUT_CTRL, d);
        `CHK("output control reset", 16'h0000, d)
        rd(32'hffff_c3f0, d);
        `CHK("unmapped read", 16'h0000, d)
        `CHK("upper after reset", 3'h7, upper_o)
        `CHK("lower after reset", 3'h7, lower_o)
        wr(`MPO_ADDR_OUT_CTRL, 16'hffff);
        rd(`MPO_ADDR_OUT_CTRL, d);
        `CHK("output control layout", 16'h1fff, d)
        $display("test reset and layout done");
    endtask : t_reset
    task automatic t_fixed;
        logic [1:0] u, v, w;
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                u = c[1:0];
                v = u + 2'h1;
                w = u + 2'h2;
                pol_hi <= p[1];
                pol_lo <= p[0];
                wr(`MPO_ADDR_OUT_CTRL, {3'h0, p[1], p[0], 5'h00, w, v, u});
                cyc(3);
                `CHK("fixed upper on", {w[1], v[1], u[1]}, gate_u)
                `CHK("fixed lower on", {w[0], v[0], u[0]}, gate_l)
                `CHK("fixed upper", {w[1], v[1], u[1]} ^ {3{~p[1]}}, upper_o)
            end
        end
        $display("test fixed levels done");
    endtask : t_fixed
    task automatic t_pwm;
        logic [2:0] eu, el;
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr(`MPO_ADDR_OUT_CTRL, {3'h0, p[1], p[0], 5'h1c, {3{c[1:0]}}});
                for (int k = 0; k < 2; k++) begin
                    wave_upper_i <= k[0] ? 3'h5 : 3'h2;
                    wave_lower_i <= k[0] ? 3'h3 : 3'h4;
                    cyc(3);
                    eu = (c == 1) ? {3{~p[1]}} : wave_upper_i;
                    el = (c == 2) ? {3{~p[0]}} : wave_lower_i;
                    `CHK("waveform upper", eu, upper_o)
                    `CHK("waveform lower", el, lower_o)
                end
            end
        end
        $display("test waveform mode done");
    endtask : t_pwm
    task automatic t_xfer;
        logic [1:0] cd, prev;
        wr(`MPO_ADDR_PERIOD, 16'h0010);
        wr(`MPO_ADDR_OUT_CTRL, 16'h1800);
        prev = 2'b00;
        for (int t = 1; t < 4; t++) begin
            cd = (t == 1) ? 2'b10 : (t == 2) ? 2'b01 : 2'b11;
            wr(`MPO_ADDR_CHAN_CTRL, 16'h0000);
            wr(`MPO_ADDR_OUT_CTRL, {8'h18, t[1:0], {3{cd}}});
            cyc(4);
            chk_lines(prev);
            `CHK("load idle", 1'b0, load_o)
            wr(`MPO_ADDR_CHAN_CTRL, 16'h0001);
            wait_cnt(16'h0001);
            cyc(3);
            chk_lines((t == 2) ? prev : cd);
            wait_cnt(16'h0010);
            cyc(3);
            chk_lines(cd);
            prev = cd;
        end
        $display("test transfer timing done");
    endtask : t_xfer
    task automatic t_count;
        wait_cnt(16'h0001);
        cyc(15);
        `CHK("count at period", 16'h0010, count_o)
        cyc(1);
        `CHK("count wraps", 16'h0001, count_o)
        wr(`MPO_ADDR_CHAN_CTRL, 16'h0000);
        cyc(3);
        `CHK("count cleared", 16'h0000, count_o)
        $display("test counter done");
    endtask : t_count
    task automatic t_sync;
        logic [15:0] d;
        wr(`MPO_ADDR_CHAN_CTRL, 16'h0041);
        cyc(10);
        `CHK("standby count", 16'h0000, count_o)
        rd(`MPO_ADDR_CHAN_CTRL, d);
        `CHK("standby status", 16'h8041, d)
        `CHK("local run", 1'b1, local_run_o)
        @(posedge clk_i);
        peer_run_i <= 1'b1;
        wait_cnt(16'h0001);
        wr(`MPO_ADDR_CHAN_CTRL, 16'h0000);
        wr(`MPO_ADDR_CHAN_CTRL, 16'h0041);
        cyc(2);
        `CHK("second starter runs", 1'b1, count_o != 16'h0000)
        wr(`MPO_ADDR_CHAN_CTRL, 16'h0000);
        peer_run_i <= 1'b0;
        $display("test synchronized start done");
    endtask : t_sync
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cyc(1);
        t_reset();
        t_fixed();
        t_pwm();
        t_xfer();
        t_count();
        t_sync();
        final_report();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        final_report();
    end
endmodule : motor_pwm_output_conduction_tb_top
bind mpo_top mpo_top_properties #(.DATA_W(DATA_W), .CNT_W(CNT_W)) u_props (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .peer_run_i(peer_run_i), .local_run_o(local_run_o),
    .wave_upper_i(wave_upper_i), .wave_lower_i(wave_lower_i), .upper_o(upper_o),
    .lower_o(lower_o), .count_o(count_o), .load_o(load_o));
